// ---- verilog/shs_regs.svh ----
`ifndef SHS_REGS_SVH
`define SHS_REGS_SVH
// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define SHS_WAKE_VEC_MAIN 8'hB
`define SHS_WAKE_VEC_SUB 8'h9
`define SHS_WAKE_PLAIN_MAIN 8'h5
`define SHS_WAKE_PLAIN_SUB 8'h3
`define SHS_STAB_SEL_RST 3'h7
`define SHS_STAB_BASE_LOG2 8
`endif

// ---- verilog/shs_pkg.sv ----
`default_nettype none
package shs_pkg;
  typedef enum logic [1:0] {SHS_RUN, SHS_HALT, SHS_STOP} shs_state_t;
  typedef enum logic [1:0] {
    SHS_CLK_IHS, SHS_CLK_IHS20, SHS_CLK_XTAL, SHS_CLK_SUB
  } shs_clk_t;
endpackage : shs_pkg
`default_nettype wire

// ---- verilog/shs_standby_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "shs_regs.svh"
module shs_standby_ctrl (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic halt_exec_i,
  input wire logic stop_exec_i,
  input wire shs_pkg::shs_clk_t core_clk_sel_i,
  input wire logic ext_clk_mode_i,
  input wire logic irq_pending_i,
  input wire logic irq_ack_en_i,
  input wire logic ihs_on_i,
  input wire logic ihs20_on_i,
  input wire logic xtal_on_i,
  input wire logic sub_on_i,
  input wire logic wdog_enable_opt_i,
  input wire logic wdog_standby_keep_i,
  input wire logic subclk_lowpower_halt_i,
  input wire logic [2:0] stab_wait_select_i,
  input wire logic sub_tick_i,
  input wire logic xtal_tick_i,
  output shs_pkg::shs_state_t state_o,
  output logic core_clk_en_o,
  output logic wake_busy_o,
  output logic vector_req_o,
  output logic ihs_run_o,
  output logic xtal_run_o,
  output logic ext_clk_run_o,
  output logic sub_run_o,
  output logic lowspd_wdog_run_o,
  output logic hold_latches_o,
  output logic flash_lp_wait_o,
  output logic periph_main_en_o,
  output logic adc_iic_en_o,
  output logic rtc_dac_en_o,
  output logic iic_addr_wake_en_o
);
  import shs_pkg::*;
  // ---------------------------------------------------------------
  // state and wake wait
  // ---------------------------------------------------------------
  shs_state_t state_reg;
  logic entered_sub_reg;
  logic waiting_reg;
  logic stab_reg;
  logic vec_reg;
  logic [7:0] wait_cnt_reg;
  logic [18:0] stab_cnt_reg;
  logic on_sub;
  logic on_main;
  logic stop_ok;
  logic [7:0] wake_len;
  assign on_sub = (core_clk_sel_i == SHS_CLK_SUB);
  assign on_main = !on_sub;
  // stop from the 20 MHz source is the caller's fault; refused here
  assign stop_ok = on_main && (core_clk_sel_i != SHS_CLK_IHS20);

  function automatic logic [7:0] wake_cycles(input logic vec,
                                             input logic sub);
    if (vec)
      wake_cycles = sub ? `SHS_WAKE_VEC_SUB : `SHS_WAKE_VEC_MAIN;
    else
      wake_cycles = sub ? `SHS_WAKE_PLAIN_SUB : `SHS_WAKE_PLAIN_MAIN;
  endfunction : wake_cycles

  function automatic logic [18:0] stab_cycles(input logic [2:0] sel);
    logic [4:0] lg;
    lg = 5'd0;
    unique case (sel)
      3'h0: lg = 5'd8;
      3'h1: lg = 5'd9;
      3'h2: lg = 5'd10;
      3'h3: lg = 5'd11;
      3'h4: lg = 5'd13;
      3'h5: lg = 5'd15;
      3'h6: lg = 5'd17;
      3'h7: lg = 5'd18;
    endcase
    stab_cycles = 19'(19'h1 << lg);
  endfunction : stab_cycles

  assign wake_len = wake_cycles(irq_ack_en_i, on_sub);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= SHS_RUN;
      entered_sub_reg <= 1'b0;
      waiting_reg <= 1'b0;
      stab_reg <= 1'b0;
      vec_reg <= 1'b0;
      wait_cnt_reg <= 8'h0;
      stab_cnt_reg <= 19'h0;
    end else begin
      unique case (state_reg)
        SHS_RUN: begin
          if (halt_exec_i) begin
            state_reg <= SHS_HALT;
            entered_sub_reg <= on_sub;
          end else if (stop_exec_i && stop_ok) begin
            entered_sub_reg <= 1'b0;
            if (irq_pending_i) begin
              // pending request: degrade to halt, still pay stabilization
              state_reg <= SHS_HALT;
              waiting_reg <= 1'b1;
              stab_reg <= (core_clk_sel_i == SHS_CLK_XTAL) && !ext_clk_mode_i;
              stab_cnt_reg <= stab_cycles(stab_wait_select_i);
              vec_reg <= irq_ack_en_i;
              wait_cnt_reg <= wake_len;
            end else begin
              state_reg <= SHS_STOP;
            end
          end
        end
        SHS_HALT: begin
          if (!waiting_reg && irq_pending_i) begin
            waiting_reg <= 1'b1;
            vec_reg <= irq_ack_en_i;
            wait_cnt_reg <= wake_len;
          end else if (waiting_reg) begin
            if (stab_reg) begin
              if (xtal_tick_i)
                stab_cnt_reg <= stab_cnt_reg - 19'h1;
              if (stab_cnt_reg <= 19'h1 && xtal_tick_i)
                stab_reg <= 1'b0;
            end else if (!entered_sub_reg || sub_tick_i) begin
              // subclock waits count subclock edges, not system cycles
              if (wait_cnt_reg <= 8'h1) begin
                state_reg <= SHS_RUN;
                waiting_reg <= 1'b0;
              end else begin
                wait_cnt_reg <= wait_cnt_reg - 8'h1;
              end
            end
          end
        end
        SHS_STOP: begin
          if (irq_pending_i) begin
            state_reg <= SHS_HALT;
            waiting_reg <= 1'b1;
            stab_reg <= (core_clk_sel_i == SHS_CLK_XTAL) && !ext_clk_mode_i;
            stab_cnt_reg <= stab_cycles(stab_wait_select_i);
            vec_reg <= irq_ack_en_i;
            wait_cnt_reg <= wake_len;
          end
        end
        default: state_reg <= SHS_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  shs_state_t st_n;
  logic in_halt;
  logic in_stop;
  logic halt_sub;
  always_comb begin
    st_n = state_reg;
    in_halt = (state_reg == SHS_HALT);
    in_stop = (state_reg == SHS_STOP);
    halt_sub = in_halt && entered_sub_reg;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_o <= SHS_RUN;
      core_clk_en_o <= 1'b1;
      wake_busy_o <= 1'b0;
      vector_req_o <= 1'b0;
    end else begin
      state_o <= st_n;
      core_clk_en_o <= (st_n == SHS_RUN);
      wake_busy_o <= waiting_reg;
      vector_req_o <= in_halt && waiting_reg && vec_reg &&
                      !stab_reg && wait_cnt_reg <= 8'h1 &&
                      (!entered_sub_reg || sub_tick_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ihs_run_o <= 1'b1;
      xtal_run_o <= 1'b0;
      ext_clk_run_o <= 1'b0;
      sub_run_o <= 1'b0;
      lowspd_wdog_run_o <= 1'b0;
    end else begin
      // core source forced on outside stop; crystal and external input exclusive
      ihs_run_o <= !in_stop && (ihs_on_i || ihs20_on_i ||
                   core_clk_sel_i == SHS_CLK_IHS ||
                   core_clk_sel_i == SHS_CLK_IHS20);
      xtal_run_o <= !in_stop && !ext_clk_mode_i &&
                    (xtal_on_i || core_clk_sel_i == SHS_CLK_XTAL);
      ext_clk_run_o <= !in_stop && ext_clk_mode_i &&
                       (xtal_on_i || core_clk_sel_i == SHS_CLK_XTAL);
      sub_run_o <= sub_on_i || core_clk_sel_i == SHS_CLK_SUB;
      lowspd_wdog_run_o <= (state_reg == SHS_RUN) ? wdog_enable_opt_i :
                           (wdog_enable_opt_i && wdog_standby_keep_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_latches_o <= 1'b0;
      flash_lp_wait_o <= 1'b0;
      periph_main_en_o <= 1'b1;
      adc_iic_en_o <= 1'b1;
      rtc_dac_en_o <= 1'b1;
      iic_addr_wake_en_o <= 1'b0;
    end else begin
      hold_latches_o <= !(st_n == SHS_RUN);
      flash_lp_wait_o <= halt_sub;
      periph_main_en_o <= !in_stop &&
                          !(halt_sub && subclk_lowpower_halt_i);
      adc_iic_en_o <= !in_stop && !halt_sub;
      rtc_dac_en_o <= !(halt_sub && subclk_lowpower_halt_i);
      iic_addr_wake_en_o <= in_stop;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_core_clk_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    state_o != SHS_RUN |-> !core_clk_en_o)
    else $error("core clock runs in standby");
  a_halt_entry: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_RUN && halt_exec_i |=> state_reg == SHS_HALT)
    else $error("halt not entered");
  a_stop_refused: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_RUN && !halt_exec_i && stop_exec_i && on_sub
    |=> state_reg == SHS_RUN)
    else $error("stop entered from subclock");
  a_stop_degrade: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_RUN && !halt_exec_i && stop_exec_i && stop_ok &&
    irq_pending_i |=> state_reg == SHS_HALT)
    else $error("stop not degraded");
  a_stop_osc_off: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_STOP |=> !ihs_run_o && !xtal_run_o && !ext_clk_run_o)
    else $error("main osc runs in stop");
  a_wdog_standby: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg != SHS_RUN && !wdog_standby_keep_i |=> !lowspd_wdog_run_o)
    else $error("watchdog runs in standby");
  a_iic_wake: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_STOP |=> iic_addr_wake_en_o && !periph_main_en_o)
    else $error("stop peripheral state wrong");
  a_plain_wake: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_HALT && !waiting_reg && irq_pending_i &&
    !irq_ack_en_i && !entered_sub_reg
    |=> waiting_reg [*5] ##1 state_reg == SHS_RUN)
    else $error("plain wake length wrong");
  a_vec_wake: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_HALT && !waiting_reg && irq_pending_i &&
    irq_ack_en_i && !entered_sub_reg
    |=> waiting_reg [*8] ##4 state_reg == SHS_RUN)
    else $error("vectored wake length wrong");
  a_flash_lp: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == SHS_HALT && entered_sub_reg |=> flash_lp_wait_o &&
    !adc_iic_en_o)
    else $error("subclock halt peripherals wrong");
endmodule : shs_standby_ctrl
`default_nettype wire

// ---- tb/shs_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module shs_osc_model #(
  parameter int SUB_DIV = 4,
  parameter int XTAL_DIV = 2
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sub_run_i,
  output logic sub_tick_o,
  output logic xtal_tick_o
);
  int sub_cnt;
  int xtal_cnt;
  // ----------------------------------------
  // subclock ticks, stand still when stopped
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i || !sub_run_i) begin
      sub_cnt <= 0;
      sub_tick_o <= 1'b0;
    end else begin
      sub_cnt <= (sub_cnt == SUB_DIV - 1) ? 0 : sub_cnt + 1;
      sub_tick_o <= (sub_cnt == SUB_DIV - 1);
    end
  end
  // ----------------------------------------
  // crystal ticks, free running, keep ticking through stop
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      xtal_cnt <= 0;
      xtal_tick_o <= 1'b0;
    end else begin
      xtal_cnt <= (xtal_cnt == XTAL_DIV - 1) ? 0 : xtal_cnt + 1;
      xtal_tick_o <= (xtal_cnt == XTAL_DIV - 1);
    end
  end
endmodule : shs_osc_model
`default_nettype wire

// ---- tb/standby_halt_stop_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module standby_halt_stop_control_bench;
  import shs_pkg::*;
  typedef struct {
    shs_clk_t sel;
    logic ack;
    logic sub;
    int lo;
    int hi;
  } shs_row_t;
  logic clock_i, rst_i, hlt, stp, irq, ack, x_on, s_on, lp, st_tick, xt_tick;
  logic ext, keep;
  logic [2:0] stab;
  shs_clk_t sel;
  shs_state_t state;
  logic clk_en, busy, vreq, ihs_run, x_run, e_run, s_run, wd_run, hold;
  logic flp, pmain, adc, rtc, iicw, v;
  int mismatches, checked, cycles, nb, ns, nx;
  // vectored and plain wake windows, main counts clocks, sub counts ticks
  shs_row_t rows[5] = '{'{SHS_CLK_IHS, 0, 0, 5, 6},
    '{SHS_CLK_IHS20, 1, 0, 10, 12},
    '{SHS_CLK_XTAL, 0, 0, 5, 6}, '{SHS_CLK_SUB, 0, 1, 3, 4},
    '{SHS_CLK_SUB, 1, 1, 8, 10}};
  shs_standby_ctrl DUT (.clock_i(clock_i), .rst_i(rst_i), .halt_exec_i(hlt),
    .stop_exec_i(stp), .core_clk_sel_i(sel), .ext_clk_mode_i(ext),
    .irq_pending_i(irq), .irq_ack_en_i(ack), .ihs_on_i(1'b1),
    .ihs20_on_i(1'b0), .xtal_on_i(x_on), .sub_on_i(s_on),
    .wdog_enable_opt_i(1'b1), .wdog_standby_keep_i(keep),
    .subclk_lowpower_halt_i(lp), .stab_wait_select_i(stab),
    .sub_tick_i(st_tick), .xtal_tick_i(xt_tick), .state_o(state),
    .core_clk_en_o(clk_en), .wake_busy_o(busy), .vector_req_o(vreq),
    .ihs_run_o(ihs_run), .xtal_run_o(x_run), .ext_clk_run_o(e_run),
    .sub_run_o(s_run), .lowspd_wdog_run_o(wd_run), .hold_latches_o(hold),
    .flash_lp_wait_o(flp), .periph_main_en_o(pmain), .adc_iic_en_o(adc),
    .rtc_dac_en_o(rtc), .iic_addr_wake_en_o(iicw));
  shs_osc_model osc (.clock_i(clock_i), .rst_i(rst_i), .sub_run_i(s_run),
    .sub_tick_o(st_tick), .xtal_tick_o(xt_tick));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic pulse(input logic is_halt);
    @(posedge clock_i);
    hlt <= is_halt;
    stp <= !is_halt;
    @(posedge clock_i);
    hlt <= 1'b0;
    stp <= 1'b0;
    tick(1);
  endtask : pulse
  // irq held until the core runs again; bounded so a hang cannot stall
  task automatic wake();
    int k;
    logic pt;
    pt = 1'b0;
    nb = 0;
    ns = 0;
    nx = 0;
    v = 1'b0;
    @(posedge clock_i);
    irq <= 1'b1;
    for (k = 0; k < 3000 && state !== SHS_RUN; k++) begin
      tick(1);
      nb += busy;
      // busy lags the wait by one edge, so pair it with the previous tick
      ns += pt & busy;
      pt = st_tick;
      nx += xt_tick;
      v |= vreq;
    end
    @(posedge clock_i);
    irq <= 1'b0;
    tick(1);
  endtask : wake
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {hlt, stp, irq, ack, x_on, s_on, lp, ext} = '0;
    keep = 1'b1;
    rst_i = 1'b1;
    stab = 3'h0;
    sel = SHS_CLK_IHS;
    tick(5);
    rst_i <= 1'b0;
    tick(1);
    check(state, SHS_RUN);
    check({clk_en, ihs_run}, 2'h3);
    foreach (rows[i]) begin
      sel <= rows[i].sel;
      ack <= rows[i].ack;
      s_on <= rows[i].sub;
      pulse(1'b1);
      check(state, SHS_HALT);
      check({clk_en, hold}, 2'h1);
      check({flp, adc}, {rows[i].sub, !rows[i].sub});
      check(x_run, rows[i].sel == SHS_CLK_XTAL);
      check(wd_run, 1'b1);
      wake();
      check((rows[i].sub ? ns : nb) inside {[rows[i].lo:rows[i].hi]}, 1);
      check(v, rows[i].ack);
      check({state, clk_en}, {SHS_RUN, 1'b1});
    end
    pulse(1'b0);
    check(state, SHS_RUN);
    sel <= SHS_CLK_IHS;
    pulse(1'b0);
    check({state, clk_en}, {SHS_STOP, 1'b0});
    check({ihs_run, x_run, e_run, s_run}, 4'h1);
    check({pmain, rtc, iicw}, 3'h3);
    wake();
    check(state, SHS_RUN);
    irq <= 1'b1;
    pulse(1'b0);
    check(state, SHS_HALT);
    wake();
    sel <= SHS_CLK_SUB;
    lp <= 1'b1;
    pulse(1'b1);
    check(pmain, 1'b0);
    wake();
    lp <= 1'b0;
    sel <= SHS_CLK_XTAL;
    x_on <= 1'b1;
    pulse(1'b0);
    wake();
    check(nx >= 256, 1);
    ext <= 1'b1;
    keep <= 1'b0;
    pulse(1'b1);
    check({x_run, e_run, wd_run}, 3'h2);
    wake();
    check(state, SHS_RUN);
    ext <= 1'b0;
    keep <= 1'b1;
    pulse(1'b1);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    check({state, clk_en}, {SHS_RUN, 1'b1});
    stop_test();
  end
endmodule : standby_halt_stop_control_bench
`default_nettype wire
